// ===== src/lfc_top.sv
`timescale 1ns/10ps
`include "lfc_regs.svh"
module lfc_top import lfc_pkg::*; #(
  parameter int NUM_OUT     = 4,
  parameter int LED_DGL_CYC = `LFC_LED_DGL_CYC,
  parameter int OUT_DGL_CYC = `LFC_OUT_DGL_CYC
) (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_resetn,
  // Chip enable pin
  input  wire logic                 i_chip_en,
  // Register access from the serial interface engine
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  input  wire logic [7:0]           i_reg_addr,
  input  wire logic [7:0]           i_reg_wdata,
  output logic [7:0]                o_reg_rdata,
  // Supply comparators
  input  wire logic                 i_uvlo_trip,
  input  wire logic                 i_vin_ok,
  // Short, overvoltage and thermal comparators
  input  wire logic [NUM_OUT-1:0]   i_led_short,
  input  wire logic                 i_out_short,
  input  wire logic                 i_ovp_edge,
  input  wire logic                 i_tsd,
  input  wire logic                 i_tsb,
  input  wire logic                 i_tsb_shutdown,
  // Thermistor channels and assignment
  input  wire logic [1:0]           i_ntc_trip,
  input  wire logic [1:0]           i_ntc_open,
  input  wire logic [1:0]           i_ntc_short,
  input  wire logic [1:0]           i_ntc_shutdown,
  input  wire logic [NUM_OUT-1:0]   i_ntc_assign,
  // Timer and non-clearing events
  input  wire logic [NUM_OUT-1:0]   i_flash_timeout,
  input  wire logic                 i_icl,
  input  wire logic                 i_tx,
  input  wire logic                 i_ivfm,
  // Strobe and torch pins with configuration
  input  wire logic [1:0]           i_strobe,
  input  wire logic [NUM_OUT-1:0]   i_str_en,
  input  wire logic [NUM_OUT-1:0]   i_str_sel,
  input  wire logic                 i_torch_pin,
  input  wire logic                 i_torch_pin_en,
  // Brightness targets and ramp settings
  input  wire logic [NUM_OUT*8-1:0] i_flash_tgt,
  input  wire logic [NUM_OUT*8-1:0] i_torch_tgt,
  input  wire logic [7:0]           i_torch_ramp_div,
  input  wire logic                 i_ir_no_ramp,
  // Analog side controls
  output logic [NUM_OUT*8-1:0]      o_level,
  output logic                      o_boost_en,
  output logic                      o_standby
);

  ////////////////////////////////////////////////////////////////////////
  // Parameter checks

  generate
    if (NUM_OUT != 4) begin : g_chk_out
      $error("register layout serves exactly four outputs");
    end
    if (LED_DGL_CYC < 2 || OUT_DGL_CYC < 2) begin : g_chk_dgl
      $error("deglitch counts too short");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0]         en_ff;
  logic [7:0]         mode_ff;
  logic [7:0]         vflt_ff;
  logic [7:0]         tflt_ff;
  logic [7:0]         rdata_ff;
  logic [1:0]         ovp_cnt_ff;
  logic [7:0]         div_cnt_ff;
  logic               boost_ff;
  logic               standby_ff;
  logic [7:0]         nxt_en;
  logic [7:0]         nxt_mode;
  logic [7:0]         nxt_vflt;
  logic [7:0]         nxt_tflt;
  logic [7:0]         nxt_rdata;
  logic [1:0]         nxt_ovp_cnt;
  logic [7:0]         nxt_div_cnt;
  logic [NUM_OUT-1:0] led_hit;
  logic [NUM_OUT-1:0] src_on;
  logic [NUM_OUT-1:0] torch_run;
  logic [NUM_OUT-1:0] short_arm;
  logic [NUM_OUT-1:0] ir_arm;
  logic [NUM_OUT-1:0] fto_hit;
  logic [NUM_OUT-1:0] ntc_clr;
  logic               out_hit;

  ////////////////////////////////////////////////////////////////////////
  // Register access decode

  wire wr_en    = i_reg_wr & (i_reg_addr == `LFC_ADDR_EN);
  wire wr_mode  = i_reg_wr & (i_reg_addr == `LFC_ADDR_MODE);
  wire rd_vflt  = i_reg_rd & (i_reg_addr == `LFC_ADDR_VFLT);
  wire rd_tflt  = i_reg_rd & (i_reg_addr == `LFC_ADDR_TFLT);
  wire sw_rst   = wr_en & i_reg_wdata[`LFC_EN_SWRST_BIT];
  wire any_flag = (|vflt_ff) | (|tflt_ff);

  // Restart refused while flagged or supply not recovered
  wire lock     = any_flag | ~i_vin_ok;

  ////////////////////////////////////////////////////////////////////////
  // Ramp rate divider for torch

  wire div_end  = (div_cnt_ff >= i_torch_ramp_div);
  wire tstep    = div_end;

  // Wraps at the programmed ramp period
  assign nxt_div_cnt = div_end ? 8'h00 : div_cnt_ff + 8'h01;

  ////////////////////////////////////////////////////////////////////////
  // Per-output mode decode, ramp and short deglitch

  wire pin_torch = i_torch_pin_en & i_torch_pin;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      lfc_mode_t md;
      logic      str_lvl;
      logic      flash_run;
      logic      ir_run;
      logic      output_enable_bits;

      assign md      = mode_ff[2*gi+1:2*gi];
      assign output_enable_bits   = en_ff[gi];
      assign str_lvl = i_str_sel[gi] ? i_strobe[1] : i_strobe[0];

      // Torch by mode code or by the enabled torch pin
      assign torch_run[gi] = output_enable_bits &
        ((md == `LFC_MODE_TORCH) | pin_torch);
      // Flash runs from register or while its strobe is high
      assign flash_run = output_enable_bits & ~torch_run[gi] &
        (md == `LFC_MODE_FLASH) & (~i_str_en[gi] | str_lvl);
      // IR pulses follow the strobe level alone
      assign ir_arm[gi] = output_enable_bits & (md == `LFC_MODE_IR);
      assign ir_run     = ir_arm[gi] & ~pin_torch & str_lvl;
      assign src_on[gi] = torch_run[gi] | flash_run | ir_run;
      // Short detection only counts in torch or flash
      assign short_arm[gi] = torch_run[gi] | flash_run;
      // Timeout only matters to flash outputs, never torch
      assign fto_hit[gi] = i_flash_timeout[gi] &
        (md == `LFC_MODE_FLASH) & ~torch_run[gi];
      // Thermistor faults hit outputs of their channel
      assign ntc_clr[gi] = i_ntc_assign[gi] ?
        ((i_ntc_trip[1] & i_ntc_shutdown[1]) | i_ntc_open[1] |
         i_ntc_short[1]) :
        ((i_ntc_trip[0] & i_ntc_shutdown[0]) | i_ntc_open[0] |
         i_ntc_short[0]);

      lfc_deglitch #(
        .CYC (LED_DGL_CYC)
      ) u_led_dgl (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_arm      (short_arm[gi]),
        .i_cond     (i_led_short[gi]),
        .o_valid_ff (led_hit[gi])
      );

      // Torch target and torch rate; flash and IR use flash level
      lfc_ramp u_ramp (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_on       (src_on[gi] & ~lock),
        .i_step     (torch_run[gi] ? tstep : 1'b1),
        .i_jump     (ir_run & i_ir_no_ramp),
        .i_target   (torch_run[gi] ? i_torch_tgt[8*gi+7:8*gi] :
                     i_flash_tgt[8*gi+7:8*gi]),
        .o_level_ff (o_level[8*gi+7:8*gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Boost output short deglitch

  lfc_deglitch #(
    .CYC (OUT_DGL_CYC)
  ) u_out_dgl (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_arm      (|src_on),
    .i_cond     (i_out_short),
    .o_valid_ff (out_hit)
  );

  ////////////////////////////////////////////////////////////////////////
  // Overvoltage edge counting

  // Third rising edge while driving is a real fault
  wire ovp_hit = i_ovp_edge & (ovp_cnt_ff == (`LFC_OVP_EDGES - 2'h1));

  assign nxt_ovp_cnt = (~(|src_on) | sw_rst) ? 2'h0 :
                       (i_ovp_edge & ~ovp_hit) ? ovp_cnt_ff + 2'h1 :
                       ovp_cnt_ff;

  ////////////////////////////////////////////////////////////////////////
  // Fault to enable clearing matrix

  // Current limit, transmit and low-battery events clear nothing
  wire no_clr_evt = i_icl | i_tx | i_ivfm;
  wire tsb_sd     = i_tsb & i_tsb_shutdown;
  wire glob_flt   = out_hit | ovp_hit | i_uvlo_trip | i_tsd;
  // Register-started flash timeout clears every output
  wire fto_all    = |(fto_hit & ~i_str_en);
  // Strobe flash keeps enables; a timeout hits its own output
  wire [NUM_OUT-1:0] fto_own = fto_hit & i_str_en;

  wire [NUM_OUT-1:0] clr_dx =
    {NUM_OUT{glob_flt | tsb_sd | fto_all | ~i_chip_en}} |
    led_hit | fto_own | ntc_clr;
  wire clr_rail = glob_flt | tsb_sd | ~i_chip_en;

  ////////////////////////////////////////////////////////////////////////
  // Enable register next value

  // While locked, a write may only drop bits, never raise them
  wire [7:0] en_wr = lock ? (en_ff & i_reg_wdata) :
                     (i_reg_wdata & `LFC_EN_WMASK);
  wire [7:0] en_base = wr_en ? en_wr : en_ff;
  wire [7:0] en_keep = {3'h0, ~clr_rail, ~clr_dx};

  assign nxt_en = (sw_rst | no_clr_evt & 1'b0) ? `LFC_EN_RST :
                  (en_base & en_keep);

  ////////////////////////////////////////////////////////////////////////
  // Mode register next value

  // Writes ignored while any fault flag stands
  assign nxt_mode = sw_rst ? `LFC_MODE_RST :
                    (wr_mode & ~any_flag) ? i_reg_wdata : mode_ff;

  ////////////////////////////////////////////////////////////////////////
  // Voltage fault flags, set wins over clear

  wire       vf_clr  = rd_vflt | sw_rst;
  wire       led_clr = vf_clr | ~i_chip_en;
  wire [7:0] vf_set;
  wire [7:0] vf_keep;

  assign vf_set[`LFC_VF_UVLO_BIT]   = i_uvlo_trip;
  assign vf_set[`LFC_VF_OSHORT_BIT] = out_hit | ovp_hit;
  assign vf_set[5:4]                = 2'h0;
  assign vf_set[3:0]                = led_hit;
  assign vf_keep = {~vf_clr, ~vf_clr, 2'h0, {4{~led_clr}}};

  assign nxt_vflt = (vflt_ff & vf_keep) | vf_set;

  ////////////////////////////////////////////////////////////////////////
  // Thermal fault flags, set wins over clear

  wire       tf_clr = rd_tflt | sw_rst;
  wire [7:0] tf_set;

  assign tf_set[`LFC_TF_TSD_BIT] = i_tsd;
  assign tf_set[`LFC_TF_TSB_BIT] = tsb_sd;
  assign tf_set[3:2]             = 2'h0;
  assign tf_set[5:4]             = i_ntc_open;
  assign tf_set[7:6]             = i_ntc_short;

  assign nxt_tflt = (tf_clr ? `LFC_FLT_RST : tflt_ff) | tf_set;

  ////////////////////////////////////////////////////////////////////////
  // Read data selection

  assign nxt_rdata =
    (i_reg_addr == `LFC_ADDR_EN)   ? en_ff   :
    (i_reg_addr == `LFC_ADDR_MODE) ? mode_ff :
    (i_reg_addr == `LFC_ADDR_VFLT) ? vflt_ff :
    (i_reg_addr == `LFC_ADDR_TFLT) ? tflt_ff : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Boost and standby status

  wire nxt_boost   = ~lock & ((|src_on) | (|ir_arm) |
                     en_ff[`LFC_EN_RAIL_BIT]);
  wire nxt_standby = lock | (nxt_en[4:0] == 5'h00);

  ////////////////////////////////////////////////////////////////////////
  // Control and flag registers

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      en_ff   <= `LFC_EN_RST;
      mode_ff <= `LFC_MODE_RST;
      vflt_ff <= `LFC_FLT_RST;
      tflt_ff <= `LFC_FLT_RST;
    end else begin
      en_ff   <= nxt_en;
      mode_ff <= nxt_mode;
      vflt_ff <= nxt_vflt;
      tflt_ff <= nxt_tflt;
    end
  end

  // Read data captured on a read strobe
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_ff <= 8'h00;
    end else if (i_reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Counters and status outputs
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ovp_cnt_ff <= 2'h0;
      div_cnt_ff <= 8'h00;
      boost_ff   <= 1'b0;
      standby_ff <= 1'b1;
    end else begin
      ovp_cnt_ff <= nxt_ovp_cnt;
      div_cnt_ff <= nxt_div_cnt;
      boost_ff   <= nxt_boost;
      standby_ff <= nxt_standby;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_reg_rdata = rdata_ff;
  assign o_boost_en  = boost_ff;
  assign o_standby   = standby_ff;

endmodule

// ===== src/lfc_regs.svh
`ifndef LFC_REGS_SVH
`define LFC_REGS_SVH

// Register addresses
`define LFC_ADDR_EN        8'h01
`define LFC_ADDR_MODE      8'h02
`define LFC_ADDR_VFLT      8'h15
`define LFC_ADDR_TFLT      8'h16
// Enable register fields and reset
`define LFC_EN_RAIL_BIT    4
`define LFC_EN_SWRST_BIT   7
`define LFC_EN_WMASK       8'h1F
`define LFC_EN_RST         8'h00
`define LFC_MODE_RST       8'h00
`define LFC_FLT_RST        8'h00
// Voltage fault fields
`define LFC_VF_UVLO_BIT    7
`define LFC_VF_OSHORT_BIT  6
// Thermal fault fields
`define LFC_TF_TSD_BIT     0
`define LFC_TF_TSB_BIT     1
// Output mode field codes
`define LFC_MODE_OFF       2'h0
`define LFC_MODE_IR        2'h1
`define LFC_MODE_TORCH     2'h2
`define LFC_MODE_FLASH     2'h3
// Timing
`define LFC_CLK_MHZ        40
`define LFC_LED_DGL_NS     256000
`define LFC_OUT_DGL_NS     2048000
`define LFC_LED_DGL_CYC    ((`LFC_LED_DGL_NS * `LFC_CLK_MHZ + 999) / 1000)
`define LFC_OUT_DGL_CYC    ((`LFC_OUT_DGL_NS * `LFC_CLK_MHZ + 999) / 1000)
`define LFC_OVP_EDGES      2'h3
`endif

// ===== src/lfc_pkg.sv
package lfc_pkg;
  // Two-bit output mode field
  typedef logic [1:0] lfc_mode_t;
  // Current source level code
  typedef logic [7:0] lfc_level_t;
endpackage

// ===== src/lfc_deglitch.sv
`timescale 1ns/10ps
module lfc_deglitch #(
  parameter int CYC = 16
) (
  input  wire logic i_core_clk,
  input  wire logic i_resetn,
  input  wire logic i_arm,
  input  wire logic i_cond,
  output logic      o_valid_ff
);
  localparam int W = $clog2(CYC + 1);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  wire          run = i_arm & i_cond;
  wire          done = (cnt_ff == W'(CYC - 1));

  generate
    if (CYC < 2) begin : g_chk
      $error("deglitch length too short");
    end
  endgenerate

  // Count while the condition holds, restart when it drops
  assign nxt_cnt = !run ? '0 : (done ? cnt_ff : cnt_ff + W'(1));

  // Valid only after the full interval has passed
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_ff     <= '0;
      o_valid_ff <= 1'b0;
    end else begin
      cnt_ff     <= nxt_cnt;
      o_valid_ff <= run & done;
    end
  end
endmodule

// ===== src/lfc_ramp.sv
`timescale 1ns/10ps
module lfc_ramp import lfc_pkg::*; (
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_on,
  input  wire logic       i_step,
  input  wire logic       i_jump,
  input  wire lfc_level_t i_target,
  output lfc_level_t      o_level_ff
);
  lfc_level_t nxt_level;
  wire        below = (o_level_ff < i_target);

  // Off drops to zero; on climbs one level per step, or jumps
  assign nxt_level = !i_on ? 8'h00 :
                     i_jump ? i_target :
                     (below && i_step) ? o_level_ff + 8'h01 :
                     below ? o_level_ff : i_target;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_level_ff <= 8'h00;
    end else begin
      o_level_ff <= nxt_level;
    end
  end
endmodule

// ===== test/lfc_top_properties.sv
`timescale 1ns/10ps
module lfc_top_properties import lfc_pkg::*; #(
  parameter int NUM_OUT     = 4,
  parameter int LED_DGL_CYC = 8,
  parameter int OUT_DGL_CYC = 16
) (
  input wire logic                 i_core_clk,
  input wire logic                 i_resetn,
  input wire logic                 i_chip_en,
  input wire logic                 i_reg_wr,
  input wire logic [7:0]           i_reg_addr,
  input wire logic [7:0]           i_reg_wdata,
  input wire logic                 i_uvlo_trip,
  input wire logic                 i_vin_ok,
  input wire logic                 i_out_short,
  input wire logic                 i_tsd,
  input wire logic                 i_ir_no_ramp,
  input wire logic [NUM_OUT*8-1:0] o_level,
  input wire logic                 o_boost_en,
  input wire logic                 o_standby
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  ////////////////////////////////////////////////////////////////////////////
  // Cycles spent driving an output into a shorted boost output
  logic [31:0] osc_cnt_ff;
  logic [31:0] nxt_osc_cnt;
  assign nxt_osc_cnt = (i_out_short && (o_level != '0)) ? osc_cnt_ff + 32'h1
                                                        : 32'h0;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      osc_cnt_ff <= 32'h0;
    end else begin
      osc_cnt_ff <= nxt_osc_cnt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Supply, thermal, reset and chip enable shutdown paths, ramp step limit and boost short stop
  uvlo_standby_a: assert property (i_uvlo_trip |-> ##[1:3] o_standby)
    else $error("no standby after lockout trip");
  uvlo_dark_a: assert property (i_uvlo_trip |->
    ##[1:3] (o_level == '0))
    else $error("outputs still driven after lockout trip");
  tsd_boost_off_a: assert property (i_tsd |-> ##[1:3] !o_boost_en)
    else $error("boost still on after thermal shutdown");
  supply_low_a: assert property (!i_vin_ok |-> ##[1:3] (o_level == '0))
    else $error("outputs driven while supply is low");
  swrst_dark_a: assert property ((i_reg_wr && i_reg_addr == 8'h01 &&
    i_reg_wdata[7]) |-> ##[1:3] (o_level == '0))
    else $error("outputs driven after software reset");
  chip_en_dark_a: assert property (!i_chip_en |->
    ##[1:3] (o_level == '0))
    else $error("outputs driven with chip enable low");
  ramp_step_a: assert property (
    (!i_ir_no_ramp && !$past(i_ir_no_ramp)) |->
    (o_level[7:0] <= $past(o_level[7:0]) + 8'h01))
    else $error("level rose by more than one step");
  short_stop_a: assert property (osc_cnt_ff <= OUT_DGL_CYC + 4)
    else $error("output kept driving into a boost short");
endmodule

// ===== test/lfc_host_model.sv
`timescale 1ns/10ps
module lfc_host_model (
  input  wire logic       i_core_clk,
  input  wire logic [7:0] i_reg_rdata,
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic [7:0]      o_reg_addr,
  output logic [7:0]      o_reg_wdata,
  output logic [1:0]      o_strobe,
  output logic            o_torch_pin
);
  // Idle bus and pins at time zero
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
    o_strobe = 2'h0;
    o_torch_pin = 1'b0;
  end
  // One-byte write; released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_reg_wr <= 1'b1;
    o_reg_addr <= a;
    o_reg_wdata <= d;
    @(posedge i_core_clk);
    o_reg_wr <= 1'b0;
    o_reg_addr <= ~a;
    o_reg_wdata <= ~d;
  endtask
  // One-byte read; data taken once the answer has settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    o_reg_rd <= 1'b1;
    o_reg_addr <= a;
    @(posedge i_core_clk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
    @(posedge i_core_clk);
    d = i_reg_rdata;
  endtask
  // Level-timed strobe and torch pins
  task automatic pins(input logic [1:0] s, input logic t);
    @(posedge i_core_clk);
    o_strobe <= s;
    o_torch_pin <= t;
  endtask
endmodule

// ===== test/lfc_top_tb.sv
`timescale 1ns/10ps
module lfc_top_tb import lfc_pkg::*;;
  logic i_core_clk = 1'b0, i_resetn = 1'b0, i_chip_en = 1'b1, i_vin_ok = 1'b1;
  logic i_reg_wr, i_reg_rd, i_out_short = 1'b0, i_uvlo_trip = 1'b0;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, v;
  logic [1:0] i_strobe, i_ntc_trip, i_ntc_open, i_ntc_short;
  logic [1:0] i_ntc_shutdown = 2'b10;
  logic [3:0] i_ntc_assign = 4'h1;
  logic [7:0] i_torch_ramp_div = 8'h01;
  logic [3:0] i_led_short = 4'h0, i_flash_timeout = 4'h0;
  logic [3:0] i_str_en = 4'h0, i_str_sel = 4'h0;
  logic i_torch_pin, i_torch_pin_en = 1'b0, i_ir_no_ramp = 1'b0;
  logic i_icl, i_ivfm, i_tx, i_tsb, i_tsb_shutdown, i_tsd, i_ovp_edge;
  logic [9:0] flt = 10'h000;
  logic [31:0] o_level;
  logic o_boost_en, o_standby;
  logic [7:0] exp_en [10] = '{8'h11, 8'h11, 8'h11, 8'h10, 8'h11, 8'h10,
                              8'h00, 8'h00, 8'h00, 8'h11};
  int mismatches = 0;
  int samples_checked = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Fault events, one bit per case of the fault table
  assign {i_tx, i_ovp_edge, i_tsd, i_tsb_shutdown} = {flt[9:7], flt[6]};
  assign i_tsb = flt[2] | flt[6];
  assign {i_icl, i_ivfm} = {flt[0], flt[1]};
  assign i_ntc_trip = {flt[3], 1'b0};
  assign i_ntc_short = {1'b0, flt[4]};
  assign i_ntc_open = {flt[5], 1'b0};
  always #12.5 i_core_clk = ~i_core_clk;
  lfc_top #(.LED_DGL_CYC(8), .OUT_DGL_CYC(16)) uut (.i_core_clk, .i_resetn,
    .i_chip_en, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .i_uvlo_trip, .i_vin_ok, .i_led_short, .i_out_short, .i_ovp_edge, .i_tsd,
    .i_tsb, .i_tsb_shutdown, .i_ntc_trip, .i_ntc_open, .i_ntc_short,
    .i_ntc_shutdown, .i_ntc_assign, .i_flash_timeout, .i_icl,
    .i_tx, .i_ivfm, .i_strobe, .i_str_en, .i_str_sel, .i_torch_pin,
    .i_torch_pin_en, .i_flash_tgt(32'h40302010), .i_torch_tgt(32'h08080808),
    .i_torch_ramp_div, .i_ir_no_ramp, .o_level, .o_boost_en, .o_standby);
  lfc_host_model uhost (.i_core_clk, .i_reg_rdata(o_reg_rdata),
    .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd), .o_reg_addr(i_reg_addr),
    .o_reg_wdata(i_reg_wdata), .o_strobe(i_strobe), .o_torch_pin(i_torch_pin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] want);
    logic [7:0] d;
    uhost.rd(a, d);
    chk(d, want);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic finish_test();
    $display("Counts: %0d checks, %0d mismatches", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge i_core_clk);
    mismatches++;
    finish_test();
  end
  // Test sequence
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    cyc(2);
    foreach (exp_en[k])
      rdchk(8'h01 + 8'(k == 1) + 8'(k > 1) * 8'h14 + 8'(k > 2), 8'h00);
    uhost.wr(8'h33, 8'hFF);
    rdchk(8'h33, 8'h00);
    $display("Test reset done");
    uhost.wr(8'h02, 8'h03);
    uhost.wr(8'h01, 8'h11);
    cyc(4);
    v = o_level[7:0];
    cyc(1);
    chk(o_level[7:0], v + 8'h01);
    cyc(30);
    chk(o_level[7:0], 8'h10);
    @(posedge i_core_clk) i_flash_timeout <= 4'h1;
    @(posedge i_core_clk) i_flash_timeout <= 4'h0;
    rdchk(8'h01, 8'h10);
    $display("Test flash done");
    uhost.wr(8'h02, 8'h02);
    uhost.wr(8'h01, 8'h11);
    cyc(40);
    chk(o_level[7:0], 8'h08);
    @(posedge i_core_clk) {i_flash_timeout, flt} <= {4'h1, 10'h200};
    @(posedge i_core_clk) {i_flash_timeout, flt} <= 14'h0;
    rdchk(8'h01, 8'h11);
    @(posedge i_core_clk) i_led_short <= 4'h1;
    repeat (4) @(posedge i_core_clk);
    i_led_short <= 4'h0;
    rdchk(8'h01, 8'h11);
    @(posedge i_core_clk) i_led_short <= 4'h1;
    repeat (12) @(posedge i_core_clk);
    i_led_short <= 4'h0;
    rdchk(8'h01, 8'h10);
    uhost.wr(8'h02, 8'h03);
    rdchk(8'h02, 8'h02);
    rdchk(8'h15, 8'h01);
    rdchk(8'h15, 8'h00);
    uhost.wr(8'h02, 8'h03);
    rdchk(8'h02, 8'h03);
    uhost.wr(8'h01, 8'h11);
    cyc(4);
    @(posedge i_core_clk) i_out_short <= 1'b1;
    repeat (20) @(posedge i_core_clk);
    i_out_short <= 1'b0;
    rdchk(8'h01, 8'h00);
    rdchk(8'h15, 8'h40);
    $display("Test shorts done");
    uhost.wr(8'h01, 8'h11);
    cyc(4);
    @(posedge i_core_clk) {i_uvlo_trip, i_vin_ok} <= 2'b10;
    cyc(3);
    chk(8'(o_standby), 8'h01);
    @(posedge i_core_clk) {i_uvlo_trip, i_vin_ok} <= 2'b01;
    uhost.wr(8'h01, 8'h11);
    rdchk(8'h01, 8'h00);
    rdchk(8'h15, 8'h80);
    uhost.wr(8'h01, 8'h11);
    rdchk(8'h01, 8'h11);
    cyc(30);
    chk(o_level[7:0], 8'h10);
    uhost.wr(8'h01, 8'h80);
    rdchk(8'h01, 8'h00);
    rdchk(8'h02, 8'h00);
    uhost.wr(8'h02, 8'h02);
    uhost.wr(8'h01, 8'h11);
    cyc(10);
    @(posedge i_core_clk) i_chip_en <= 1'b0;
    @(posedge i_core_clk) i_chip_en <= 1'b1;
    rdchk(8'h01, 8'h00);
    $display("Test lockout done");
    uhost.wr(8'h02, 8'h03);
    for (int k = 0; k < 10; k++) begin
      uhost.wr(8'h01, 8'h11);
      cyc(4);
      @(posedge i_core_clk) flt <= 10'h001 << k;
      repeat (3) @(posedge i_core_clk);
      flt <= 10'h000;
      rdchk(8'h01, exp_en[k]);
      uhost.rd(8'h15, v);
      uhost.rd(8'h16, v);
    end
    // Trip without shutdown setting, then short on a reassigned output
    for (int k = 3; k < 5; k++) begin
      uhost.wr(8'h01, 8'h11);
      @(posedge i_core_clk) {i_ntc_shutdown, i_ntc_assign, flt} <=
        {2'b00, 4'(k == 3), 10'h001 << k};
      repeat (3) @(posedge i_core_clk);
      flt <= 10'h000;
      rdchk(8'h01, 8'h11 - 8'(k == 4));
      uhost.rd(8'h16, v);
    end
    $display("Test fault table done");
    i_str_en <= 4'h1;
    uhost.wr(8'h01, 8'h13);
    uhost.pins(2'b01, 1'b0);
    cyc(30);
    uhost.pins(2'b00, 1'b0);
    cyc(3);
    chk(o_level[7:0], 8'h00);
    rdchk(8'h01, 8'h13);
    @(posedge i_core_clk) i_flash_timeout <= 4'h1;
    @(posedge i_core_clk) i_flash_timeout <= 4'h0;
    rdchk(8'h01, 8'h12);
    {i_str_sel, i_ir_no_ramp} <= 5'b00011;
    uhost.wr(8'h02, 8'h01);
    uhost.wr(8'h01, 8'h11);
    uhost.pins(2'b10, 1'b0);
    cyc(3);
    chk(o_level[7:0], 8'h10);
    chk(8'(o_boost_en), 8'h01);
    uhost.pins(2'b00, 1'b0);
    cyc(3);
    chk(o_level[7:0], 8'h00);
    @(posedge i_core_clk) {i_str_en, i_ir_no_ramp, i_torch_pin_en,
      i_torch_ramp_div} <= {6'b000001, 8'h02};
    uhost.wr(8'h02, 8'h00);
    uhost.pins(2'b00, 1'b1);
    cyc(40);
    chk(o_level[7:0], 8'h08);
    uhost.pins(2'b00, 1'b0);
    $display("Test strobe and pins done");
    finish_test();
  end
endmodule
bind lfc_top lfc_top_properties #(.NUM_OUT(NUM_OUT), .LED_DGL_CYC(LED_DGL_CYC),
  .OUT_DGL_CYC(OUT_DGL_CYC)) u_props (.i_core_clk, .i_resetn, .i_chip_en,
  .i_reg_wr, .i_reg_addr, .i_reg_wdata, .i_uvlo_trip, .i_vin_ok, .i_out_short,
  .i_tsd, .i_ir_no_ramp, .o_level, .o_boost_en, .o_standby);
